// ==== rtl/dit_timers.sv ====
// Dual internal timer block: CSR access, interrupt bits, arbitration and wake
// Function
// R01 - Pending/enable at mip/mie bits 29 and 28
// R02 - Timer interrupts below external, software, timer
// R03 - Cause 0x8000_001D timer zero, 0x8000_001C one
// R04 - Timer zero wins over timer one
// R05 - Interrupt is one-cycle pulse, not sticky (code holds it high while limit is zero)
// R06 - Reserved bits read zero, fields are WARL
// R07 - Count only when enable bit set
// R08 - In sleep count only if sleep enable
// R09 - While paused count only if pause enable
// R10 - No counting in debug except single step
// R11 - Counter clears when at or above limit
// R12 - Bound hit beats a same-cycle counter write
// R13 - Count resets zero, limit resets all ones
// R14 - Pause enable bit 2; interrupt ends pause
// R15 - Sleep enable bit 1; interrupt wakes core
// R16 - Enable bit 0 resets to one
// R17 - Counter advances one each qualified cycle
// R18 - Counting starts the cycle after reset
// R19 - Interrupt raised when count at/above limit
// R20 - Two identical independent timer instances
module dit_timers
  import dit_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire dit_pkg::dit_core_state_t core_state,
  input wire logic csr_we,
  input wire logic [11:0] csr_addr,
  input wire logic [31:0] csr_wdata,
  output logic [31:0] csr_rdata,
  output logic csr_hit,
  input wire logic [1:0] timer_irq_enable,
  input wire logic ext_irq,
  input wire logic sw_irq,
  input wire logic std_timer_irq,
  input wire logic [31:0] other_mip,
  output logic [31:0] mip_view,
  output logic irq_take,
  output logic [31:0] irq_cause,
  output logic timer_wake,
  output logic pause_end
);
  import dit_pkg::*;

  // ****************************************
  // Timer instances
  // ****************************************
  dit_wr_t wr0;
  dit_wr_t wr1;
  logic [31:0] cnt0;
  logic [31:0] cnt1;
  logic [31:0] lim0;
  logic [31:0] lim1;
  dit_ctl_t ctl0;
  dit_ctl_t ctl1;
  logic [1:0] timer_irq_pending;
  logic [1:0] irq_live;
  dit_src_t src;
  logic [31:0] cause_next;
  logic [31:0] rdata_next;
  logic hit_next;

  // Address decode of writes into per-timer commands
  always_comb
  begin
    wr0 = '0;
    wr1 = '0;
    wr0.wdata = csr_wdata;
    wr1.wdata = csr_wdata;
    if (csr_we && csr_addr == DIT_T0_COUNT_ADDR)
      wr0.count_we = 1'b1;
    else if (csr_we && csr_addr == DIT_T0_LIMIT_ADDR)
      wr0.limit_we = 1'b1;
    else if (csr_we && csr_addr == DIT_T0_CONTROL_ADDR)
      wr0.control_we = 1'b1;
    else if (csr_we && csr_addr == DIT_T1_COUNT_ADDR)
      wr1.count_we = 1'b1;
    else if (csr_we && csr_addr == DIT_T1_LIMIT_ADDR)
      wr1.limit_we = 1'b1;
    else if (csr_we && csr_addr == DIT_T1_CONTROL_ADDR)
      wr1.control_we = 1'b1;
  end

  // Same module twice, nothing shared but clock, reset and core state
  dit_timer u_timer0 ( // R20
    .clock(clock),
    .rst(rst),
    .core_state(core_state),
    .wr(wr0),
    .count_q(cnt0),
    .limit_q(lim0),
    .ctl_q(ctl0),
    .irq_pulse(timer_irq_pending[0])
  );

  dit_timer u_timer1 (
    .clock(clock),
    .rst(rst),
    .core_state(core_state),
    .wr(wr1),
    .count_q(cnt1),
    .limit_q(lim1),
    .ctl_q(ctl1),
    .irq_pulse(timer_irq_pending[1])
  );

  // ****************************************
  // CSR read path
  // ****************************************
  // Reads registered so data comes from flops; unmapped reads zero
  always_comb
  begin
    rdata_next = DIT_ZERO;
    hit_next = 1'b1;
    if (csr_addr == DIT_T0_COUNT_ADDR)
      rdata_next = cnt0;
    else if (csr_addr == DIT_T0_LIMIT_ADDR)
      rdata_next = lim0;
    else if (csr_addr == DIT_T0_CONTROL_ADDR)
      rdata_next = {29'h0, ctl0}; // R06
    else if (csr_addr == DIT_T1_COUNT_ADDR)
      rdata_next = cnt1;
    else if (csr_addr == DIT_T1_LIMIT_ADDR)
      rdata_next = lim1;
    else if (csr_addr == DIT_T1_CONTROL_ADDR)
      rdata_next = {29'h0, ctl1}; // R06
    else
      hit_next = 1'b0;
  end

  // Read data register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      csr_rdata <= DIT_ZERO;
      csr_hit <= 1'b0;
    end
    else
    begin
      csr_rdata <= rdata_next;
      csr_hit <= hit_next;
    end
  end

  // ****************************************
  // Pending view and arbitration
  // ****************************************
  // Pending bits merged into the core's mip image, never latched
  always_comb
  begin
    mip_view = other_mip;
    mip_view[DIT_MIP_T0_BIT] = timer_irq_pending[0]; // R01 R05
    mip_view[DIT_MIP_T1_BIT] = timer_irq_pending[1]; // R01
  end

  assign irq_live = timer_irq_pending & timer_irq_enable; // R01

  // Fixed priority: standard sources first, then timer zero, then one
  always_comb
  begin
    if (ext_irq)
      src = DIT_SRC_EXT; // R02
    else if (sw_irq)
      src = DIT_SRC_SW;
    else if (std_timer_irq)
      src = DIT_SRC_TMR;
    else if (irq_live[0])
      src = DIT_SRC_T0; // R04
    else if (irq_live[1])
      src = DIT_SRC_T1;
    else
      src = DIT_SRC_NONE;
  end

  // Cause only produced for this block's own sources
  always_comb
  begin
    case (src)
      DIT_SRC_T0: cause_next = DIT_CAUSE_T0; // R03
      DIT_SRC_T1: cause_next = DIT_CAUSE_T1; // R03
      default: cause_next = DIT_ZERO;
    endcase
  end

  // Take pulse and cause registered; one cycle late but glitch free
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      irq_take <= 1'b0;
      irq_cause <= DIT_ZERO;
    end
    else
    begin
      irq_take <= (src == DIT_SRC_T0) || (src == DIT_SRC_T1);
      irq_cause <= cause_next;
    end
  end

  // ****************************************
  // Wake requests
  // ****************************************
  // Debug halt is never left by a timer event
  always_comb
  begin
    timer_wake = core_state.sleep_state & ~core_state.debug_halted_state
      & ((irq_live[0] & ctl0.sleep_en) | (irq_live[1] & ctl1.sleep_en)); // R15
    pause_end = core_state.paused
      & ((irq_live[0] & ctl0.pause_en) | (irq_live[1] & ctl1.pause_en)); // R14
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_limit_clears: assert property (@(posedge clock) disable iff (rst) // R11
    (cnt0 >= lim0) |=> (cnt0 == DIT_ZERO))
    else $error("timer0 not cleared at limit");

  a_write_loses: assert property (@(posedge clock) disable iff (rst) // R12
    (wr1.count_we && cnt1 >= lim1) |=> (cnt1 == DIT_ZERO))
    else $error("count write beat bound clear");

  a_pulse_single: assert property (@(posedge clock) disable iff (rst) // R05
    timer_irq_pending[0] |=> !timer_irq_pending[0] || (lim0 == DIT_ZERO))
    else $error("timer0 pulse lasted two cycles");

  a_enable_gate: assert property (@(posedge clock) disable iff (rst) // R07
    (!ctl0.enable && !wr0.count_we && cnt0 < lim0) |=> $stable(cnt0))
    else $error("counted while disabled");

  a_sleep_gate: assert property (@(posedge clock) disable iff (rst) // R08
    (core_state.sleep_state && !ctl1.sleep_en && !wr1.count_we && cnt1 < lim1)
    |=> $stable(cnt1))
    else $error("counted in sleep");

  a_debug_gate: assert property (@(posedge clock) disable iff (rst) // R10
    (core_state.debug_halted_state && !core_state.single_step && !wr0.count_we
    && cnt0 < lim0) |=> $stable(cnt0))
    else $error("counted in debug halt");

  a_count_step: assert property (@(posedge clock) disable iff (rst) // R17
    (ctl0.enable && !core_state.sleep_state && !core_state.paused
    && !core_state.debug_halted_state && !wr0.count_we && cnt0 < lim0)
    |=> (cnt0 == $past(cnt0) + DIT_ONE))
    else $error("counter did not advance by one");

  a_t0_first: assert property (@(posedge clock) disable iff (rst) // R04
    (irq_live == 2'b11 && !ext_irq && !sw_irq && !std_timer_irq)
    |=> (irq_take && irq_cause == DIT_CAUSE_T0))
    else $error("timer one taken ahead of zero");

  a_std_first: assert property (@(posedge clock) disable iff (rst) // R02
    (ext_irq || sw_irq || std_timer_irq) |=> !irq_take)
    else $error("timer ahead of standard interrupt");

  a_cause_t1: assert property (@(posedge clock) disable iff (rst) // R03
    (irq_live == 2'b10 && !ext_irq && !sw_irq && !std_timer_irq)
    |=> (irq_cause == DIT_CAUSE_T1))
    else $error("wrong cause for timer one");

  // ****************************************
  // Counterpart timer checks and shared-path checks
  // ****************************************
  // Both instances are checked for the counting rules; reset values and reserved bits are checked on timer one only
  a_t1_clears: assert property (@(posedge clock) disable iff (rst) // R11
    (cnt1 >= lim1) |=> (cnt1 == DIT_ZERO))
    else $error("timer1 not cleared at limit");

  a_t0_write_loses: assert property (@(posedge clock) disable iff (rst) // R12
    (wr0.count_we && cnt0 >= lim0) |=> (cnt0 == DIT_ZERO))
    else $error("timer0 count write beat bound clear");

  a_t1_pulse_single: assert property (@(posedge clock) disable iff (rst) // R05
    timer_irq_pending[1] |=> !timer_irq_pending[1] || (lim1 == DIT_ZERO))
    else $error("timer1 pulse lasted two cycles");

  a_t1_enable_gate: assert property (@(posedge clock) disable iff (rst) // R07
    (!ctl1.enable && !wr1.count_we && cnt1 < lim1) |=> $stable(cnt1))
    else $error("timer1 counted while disabled");

  a_t0_sleep_gate: assert property (@(posedge clock) disable iff (rst) // R08
    (core_state.sleep_state && !ctl0.sleep_en && !wr0.count_we && cnt0 < lim0)
    |=> $stable(cnt0))
    else $error("timer0 counted in sleep");

  a_t0_pause_gate: assert property (@(posedge clock) disable iff (rst) // R09
    (core_state.paused && !ctl0.pause_en && !wr0.count_we && cnt0 < lim0)
    |=> $stable(cnt0))
    else $error("timer0 counted while paused");

  a_t1_pause_gate: assert property (@(posedge clock) disable iff (rst) // R09
    (core_state.paused && !ctl1.pause_en && !wr1.count_we && cnt1 < lim1)
    |=> $stable(cnt1))
    else $error("timer1 counted while paused");

  a_t1_debug_gate: assert property (@(posedge clock) disable iff (rst) // R10
    (core_state.debug_halted_state && !core_state.single_step && !wr1.count_we
    && cnt1 < lim1) |=> $stable(cnt1))
    else $error("timer1 counted in debug halt");

  a_t1_count_step: assert property (@(posedge clock) disable iff (rst) // R17
    (ctl1.enable && !core_state.sleep_state && !core_state.paused
    && !core_state.debug_halted_state && !wr1.count_we && cnt1 < lim1)
    |=> (cnt1 == $past(cnt1) + DIT_ONE))
    else $error("timer1 did not advance by one");

  // Reset values seen at the first edge after release
  a_reset_values: assert property (@(posedge clock) // R13 R16 R18
    $fell(rst) |-> (cnt1 == DIT_COUNT_RESET && lim1 == DIT_LIMIT_RESET
    && ctl1 == DIT_CTL_RESET))
    else $error("timer1 reset values wrong");

  a_ctl_reserved: assert property (@(posedge clock) disable iff (rst) // R06
    (csr_addr == DIT_T1_CONTROL_ADDR) |=> (csr_rdata[DIT_DW-1:DIT_CTL_W] == '0))
    else $error("reserved control bits not zero");

  a_mask_t1: assert property (@(posedge clock) disable iff (rst) // R01
    (!timer_irq_enable[1] && !irq_live[0]) |=> !irq_take)
    else $error("masked timer1 interrupt taken");

  a_take_cause: assert property (@(posedge clock) disable iff (rst) // R03
    irq_take |-> (irq_cause == DIT_CAUSE_T0 || irq_cause == DIT_CAUSE_T1))
    else $error("take without timer cause");

  a_take_source: assert property (@(posedge clock) disable iff (rst) // R05
    irq_take |-> $past(irq_live != 2'b00))
    else $error("take without a timer pulse");

  // Wake only matters outside debug halt; pause end has no such limit
  a_wake_t0: assert property (@(posedge clock) disable iff (rst) // R15
    (core_state.sleep_state && !core_state.debug_halted_state && irq_live[0]
    && ctl0.sleep_en) |-> timer_wake)
    else $error("timer0 interrupt did not wake");

  a_pause_t1: assert property (@(posedge clock) disable iff (rst) // R14
    (core_state.paused && irq_live[1] && ctl1.pause_en) |-> pause_end)
    else $error("timer1 interrupt did not end pause");

  c_t0_irq: cover property (@(posedge clock) disable iff (rst) irq_live[0]);
  c_both_irq: cover property (@(posedge clock) disable iff (rst) irq_live == 2'b11);
  c_wake: cover property (@(posedge clock) disable iff (rst) timer_wake);
  c_pause_end: cover property (@(posedge clock) disable iff (rst) pause_end);
  c_t1_take: cover property (@(posedge clock) disable iff (rst)
    irq_take && irq_cause == DIT_CAUSE_T1);

endmodule : dit_timers

// ==== rtl/dit_pkg.sv ====
// Package for the dual internal timer block: CSR map, fields, reset values, carriers
package dit_pkg;

  // ****************************************
  // CSR addresses and widths
  // ****************************************
  localparam int DIT_CSR_AW = 12;
  localparam int DIT_DW = 32;
  localparam logic [11:0] DIT_T0_COUNT_ADDR = 12'h7D2;
  localparam logic [11:0] DIT_T0_LIMIT_ADDR = 12'h7D3;
  localparam logic [11:0] DIT_T0_CONTROL_ADDR = 12'h7D4;
  localparam logic [11:0] DIT_T1_COUNT_ADDR = 12'h7D5;
  localparam logic [11:0] DIT_T1_LIMIT_ADDR = 12'h7D6;
  localparam logic [11:0] DIT_T1_CONTROL_ADDR = 12'h7D7;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int DIT_CTL_ENABLE_BIT = 0;
  localparam int DIT_CTL_SLEEP_BIT = 1;
  localparam int DIT_CTL_PAUSE_BIT = 2;
  localparam int DIT_CTL_W = 3;
  localparam int DIT_MIP_T0_BIT = 29;
  localparam int DIT_MIP_T1_BIT = 28;
  localparam logic [31:0] DIT_COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] DIT_LIMIT_RESET = 32'hFFFF_FFFF;
  localparam logic [2:0] DIT_CTL_RESET = 3'h1;
  localparam logic [31:0] DIT_ONE = 32'h0000_0001;
  localparam logic [31:0] DIT_ZERO = 32'h0000_0000;
  localparam logic [31:0] DIT_CAUSE_T0 = 32'h8000_001D;
  localparam logic [31:0] DIT_CAUSE_T1 = 32'h8000_001C;

  // ****************************************
  // Carriers
  // ****************************************
  // Core state shared by both timers
  typedef struct packed {
    logic sleep_state;
    logic paused;
    logic debug_halted_state;
    logic single_step;
  } dit_core_state_t;

  // CSR write command toward one timer
  typedef struct packed {
    logic count_we;
    logic limit_we;
    logic control_we;
    logic [31:0] wdata;
  } dit_wr_t;

  // Per-timer control fields
  typedef struct packed {
    logic pause_en;
    logic sleep_en;
    logic enable;
  } dit_ctl_t;

  // Interrupt sources seen by the arbiter
  typedef enum logic [2:0] {
    DIT_SRC_NONE,
    DIT_SRC_EXT,
    DIT_SRC_SW,
    DIT_SRC_TMR,
    DIT_SRC_T0,
    DIT_SRC_T1
  } dit_src_t;

endpackage : dit_pkg

// ==== rtl/dit_timer.sv ====
// One internal timer: counter, limit, control bits and interrupt pulse, one cycle long for a nonzero limit
module dit_timer
  import dit_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire dit_pkg::dit_core_state_t core_state,
  input wire dit_pkg::dit_wr_t wr,
  output logic [31:0] count_q,
  output logic [31:0] limit_q,
  output dit_pkg::dit_ctl_t ctl_q,
  output logic irq_pulse
);
  import dit_pkg::*;

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [31:0] limit_reg;
  dit_ctl_t ctl_reg;
  logic hit;
  logic inc_ok;

  // ****************************************
  // Increment gating and bound compare
  // ****************************************
  assign hit = (count_reg >= limit_reg); // R11 R19
  // Debug halt blocks counting unless a single step is executing
  assign inc_ok = ctl_reg.enable // R07 R16
    & (~core_state.sleep_state | ctl_reg.sleep_en) // R08 R15
    & (~core_state.paused | ctl_reg.pause_en) // R09 R14
    & (~core_state.debug_halted_state | core_state.single_step); // R10

  // Next count: clearing beats a CSR write so the event is not lost
  always_comb
  begin
    if (hit)
      count_next = DIT_COUNT_RESET; // R11 R12
    else if (wr.count_we)
      count_next = wr.wdata;
    else if (inc_ok)
      count_next = count_reg + DIT_ONE; // R17
    else
      count_next = count_reg;
  end

  // Counter register, starts counting the cycle after reset
  always_ff @(posedge clock)
  begin
    if (rst)
      count_reg <= DIT_COUNT_RESET; // R13 R18
    else
      count_reg <= count_next;
  end

  // Limit register takes any 32-bit value
  always_ff @(posedge clock)
  begin
    if (rst)
      limit_reg <= DIT_LIMIT_RESET; // R13
    else if (wr.limit_we)
      limit_reg <= wr.wdata;
  end

  // Control bits; upper bits are not stored and read zero
  always_ff @(posedge clock)
  begin
    if (rst)
      ctl_reg <= DIT_CTL_RESET; // R16
    else if (wr.control_we)
      ctl_reg <= wr.wdata[DIT_CTL_W-1:0]; // R06
  end

  assign count_q = count_reg;
  assign limit_q = limit_reg;
  assign ctl_q = ctl_reg;
  assign irq_pulse = hit; // R05

endmodule : dit_timer

// ==== bench/dit_core_model.sv ====
// Core-side model: sleep and pause state that a timer interrupt ends
module dit_core_model
  import dit_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic sleep_req,
  input wire logic pause_req,
  input wire logic dbg,
  input wire logic step,
  input wire logic timer_wake,
  input wire logic pause_end,
  output dit_pkg::dit_core_state_t core_state
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sleep_reg;
  logic paused_reg;

  // Sleep left only on a wake from the timer
  always_ff @(posedge clock)
  begin
    if (rst)
      sleep_reg <= 1'b0;
    else if (timer_wake)
      sleep_reg <= 1'b0;
    else if (sleep_req)
      sleep_reg <= 1'b1;
  end

  // Pause ended by a timer interrupt
  always_ff @(posedge clock)
  begin
    if (rst)
      paused_reg <= 1'b0;
    else if (pause_end)
      paused_reg <= 1'b0;
    else if (pause_req)
      paused_reg <= 1'b1;
  end

  // Debug levels come straight from the bench
  assign core_state = '{sleep_state: sleep_reg, paused: paused_reg,
                        debug_halted_state: dbg, single_step: step};
endmodule : dit_core_model

// ==== bench/dit_timers_test.sv ====
// Self-checking bench for the dual internal timer block
module dit_timers_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dit_pkg::*;
  `define CHK(got, exp) \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("[ERR] %0t got %h exp %h", $time, got, exp); \
    end
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic csr_we = 1'b0;
  logic [11:0] csr_addr = 12'h000;
  logic [31:0] csr_wdata = 32'h0000_0000;
  logic [2:0] srcs = 3'h0;
  logic sleep_req = 1'b0;
  logic pause_req = 1'b0;
  logic dbg = 1'b0;
  logic step = 1'b0;
  logic [1:0] ie = 2'h3;
  dit_core_state_t core_state;
  logic [31:0] csr_rdata;
  logic [31:0] mip_view;
  logic [31:0] irq_cause;
  logic csr_hit;
  logic irq_take;
  logic timer_wake;
  logic pause_end;
  int miscompares = 0;
  int n_checks = 0;
  int n_take = 0;

  // ****************************************
  // Clock, instances, monitors
  // ****************************************
  // Free-running core clock
  always #2 clock = ~clock;

  dit_timers dit_timers_i (.clock(clock), .rst(rst), .core_state(core_state),
    .csr_we(csr_we), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
    .csr_hit(csr_hit), .timer_irq_enable(ie), .ext_irq(srcs[0]), .sw_irq(srcs[1]),
    .std_timer_irq(srcs[2]), .other_mip(32'h0000_0000), .mip_view(mip_view),
    .irq_take(irq_take), .irq_cause(irq_cause), .timer_wake(timer_wake),
    .pause_end(pause_end));

  dit_core_model dit_core_model_i (.clock(clock), .rst(rst), .sleep_req(sleep_req),
    .pause_req(pause_req), .dbg(dbg), .step(step), .timer_wake(timer_wake),
    .pause_end(pause_end), .core_state(core_state));

  // Count taken interrupts, so ones taken while masked show up
  always @(posedge clock)
    if (irq_take === 1'b1)
      n_take <= n_take + 1;

  // ****************************************
  // Tasks and expectations
  // ****************************************
  function automatic logic [31:0] exp_ctl(input logic [31:0] d);
    return {29'h0, d[2:0]};
  endfunction : exp_ctl

  // Only the six timer addresses answer with a hit
  function automatic logic exp_hit(input logic [11:0] a);
    return (a >= DIT_T0_COUNT_ADDR) && (a <= DIT_T1_CONTROL_ADDR);
  endfunction : exp_hit

  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    csr_we <= 1'b1;
    csr_addr <= a;
    csr_wdata <= d;
    @(posedge clock);
    csr_we <= 1'b0;
  endtask : wr

  // Read data lags the address by one edge
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock);
    csr_addr <= a;
    @(posedge clock);
    #1;
    `CHK(csr_rdata, e)
    `CHK(csr_hit, exp_hit(a))
  endtask : rd

  // Bounded wait for a taken interrupt; checks latency, cause, mip bit
  task automatic wait_take(input int cyc, input logic [31:0] cause, input int b);
    int n;
    logic saw;
    n = 0;
    saw = 1'b0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
      saw = saw | mip_view[b];
    end while (irq_take !== 1'b1 && n < 60);
    if (n >= 60)
    begin
      miscompares++;
      finish_test();
    end
    `CHK(n, cyc)
    `CHK(irq_cause, cause)
    `CHK(saw, 1'b1)
  endtask : wait_take

  // ****************************************
  // Main sequence
  // ****************************************
  // Scenarios; limit kept at 3 or more so step counts never hit it
  initial
  begin
    int l;
    int t;
    logic [31:0] d;
    void'($urandom(32'h3ED136BE));
    l = 3 + $urandom % 8;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(DIT_T0_COUNT_ADDR, DIT_ONE);
    rd(DIT_T0_LIMIT_ADDR, DIT_LIMIT_RESET);
    rd(DIT_T1_CONTROL_ADDR, 32'h0000_0001);
    rd(12'h7D8, DIT_ZERO);
    repeat (4)
    begin
      d = $urandom;
      wr(DIT_T1_CONTROL_ADDR, d);
      rd(DIT_T1_CONTROL_ADDR, exp_ctl(d));
    end
    wr(DIT_T1_CONTROL_ADDR, DIT_ZERO);
    wr(DIT_T0_CONTROL_ADDR, DIT_ZERO);
    wr(DIT_T0_COUNT_ADDR, 32'h0000_0007);
    repeat (5) @(posedge clock);
    rd(DIT_T0_COUNT_ADDR, 32'h0000_0007);
    wr(DIT_T0_LIMIT_ADDR, l);
    wr(DIT_T0_COUNT_ADDR, DIT_ZERO);
    wr(DIT_T0_CONTROL_ADDR, DIT_ONE);
    wait_take(l + 1, DIT_CAUSE_T0, DIT_MIP_T0_BIT);
    @(posedge clock);
    #1;
    `CHK(irq_take, 1'b0)
    wr(DIT_T0_CONTROL_ADDR, DIT_ZERO);
    wr(DIT_T0_COUNT_ADDR, DIT_ZERO);
    wr(DIT_T0_CONTROL_ADDR, DIT_ONE);
    repeat (l - 1) @(posedge clock);
    wr(DIT_T0_COUNT_ADDR, 32'h8000_0000 | $urandom);
    rd(DIT_T0_COUNT_ADDR, DIT_ONE);
    // Each higher source in turn hides the timer interrupt
    for (int i = 0; i < 3; i++)
    begin
      wr(DIT_T0_CONTROL_ADDR, DIT_ZERO);
      srcs <= 3'h1 << i;
      wr(DIT_T0_CONTROL_ADDR, DIT_ONE);
      // Taken late so a pulse from before the mask is already counted
      t = n_take;
      repeat (l + 3) @(posedge clock);
      `CHK(n_take, t)
      srcs <= 3'h0;
    end
    // Sleep then pause: stalled without its enable, woken with it
    for (int m = 0; m < 2; m++)
    begin
      wr(DIT_T0_CONTROL_ADDR, DIT_ZERO);
      wr(DIT_T0_COUNT_ADDR, DIT_ZERO);
      @(posedge clock);
      {pause_req, sleep_req} <= m ? 2'h2 : 2'h1;
      @(posedge clock);
      {pause_req, sleep_req} <= 2'h0;
      wr(DIT_T0_CONTROL_ADDR, DIT_ONE);
      repeat (4) @(posedge clock);
      rd(DIT_T0_COUNT_ADDR, DIT_ZERO);
      wr(DIT_T0_CONTROL_ADDR, m ? 32'h0000_0005 : 32'h0000_0003);
      wait_take(l + 1, DIT_CAUSE_T0, DIT_MIP_T0_BIT);
      `CHK(m ? core_state.paused : core_state.sleep_state, 1'b0)
    end
    // Debug freezes both; single step counts; release hits both at once
    dbg <= 1'b1;
    wr(DIT_T1_CONTROL_ADDR, DIT_ONE);
    wr(DIT_T0_COUNT_ADDR, DIT_ZERO);
    wr(DIT_T1_COUNT_ADDR, DIT_ZERO);
    wr(DIT_T1_LIMIT_ADDR, l);
    repeat (5) @(posedge clock);
    rd(DIT_T1_COUNT_ADDR, DIT_ZERO);
    step <= 1'b1;
    repeat (2) @(posedge clock);
    step <= 1'b0;
    rd(DIT_T0_COUNT_ADDR, 32'h0000_0002);
    @(posedge clock);
    dbg <= 1'b0;
    wait_take(l - 1, DIT_CAUSE_T0, DIT_MIP_T1_BIT);
    @(posedge clock);
    #1;
    `CHK(irq_take, 1'b0)
    // Timer zero masked: the shared hit now yields timer one's cause
    ie <= 2'h2;
    wait_take(l, DIT_CAUSE_T1, DIT_MIP_T1_BIT);
    finish_test();
  end

  // Watchdog against a hung sequence
  initial
  begin
    repeat (50000) @(posedge clock);
    miscompares++;
    finish_test();
  end
endmodule : dit_timers_test
